// ==== sar_adc_controller.sv ====
// successive-approximation converter control: modes, sequencing, results
//
// What this block does
// - resolution select picks 10-bit or 8-bit
// - select mode: irq after each conversion
// - software mode starts on start bit set
// - hardware no-wait starts on trigger
// - hardware wait: trigger, stabilize, then convert
// - select mode converts one chosen channel
// - scan mode converts four consecutive channels
// - one-shot converts once then stops
// - sequential repeats until software stops
// - sampling lasts seven or five clocks
// - top bit set when input at or above half
// - trial next bit, keep if not below
// - trials to bit 0, or bit 2
// - copy result, irq when all done
// - word result left-justified, low six zero
// - byte result holds upper eight bits
// - irq gated by upper/lower limit compare
// - reference select bits drive reference pins
// - gate bit low holds converter reset
// - start bit reads conversion activity except in no-wait
// - bit and byte writes both accepted
// - start/enable encode stopped, standby, converting
// - one-shot auto-clear start except no-wait
`default_nettype none
module sar_adc_controller
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // processor register access
  input wire sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // configuration and trigger
  input wire conv_cfg_t cfg,
  input wire logic hw_trigger,
  // analog side
  input wire logic cmp_above,
  output logic [9:0] sar_tap,
  output logic sample_hold,
  output logic [2:0] channel_sel,
  output logic comparator_on,
  output logic converter_clock_gate,
  output logic ref_pos_ext,
  output logic ref_neg_ext,
  // results
  output logic [15:0] result_word,
  output logic [7:0] result_byte,
  output logic conversion_end_irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_STAB, ST_SAMPLE, ST_CONV} state_t;

  state_t state_reg, state_next; // sequencer state
  logic [7:0] per_reg, per_next; // peripheral clock enable
  logic [7:0] adm_reg, adm_next; // mode control
  logic [5:0] div_reg, div_next; // conversion clock divider
  logic [3:0] cnt_reg, cnt_next; // phase counter in fAD cycles
  logic [3:0] bit_reg, bit_next; // bit under trial
  logic [9:0] sar_reg, sar_next; // approximation register
  logic [1:0] scan_reg, scan_next; // scan position
  logic [2:0] ch_reg, ch_next; // channel on the mux
  logic sh_reg, sh_next; // sample switch closed
  logic [15:0] rw_reg, rw_next; // word result
  logic [7:0] rb_reg, rb_next; // byte result
  logic irq_reg, irq_next; // completion pulse
  logic [7:0] rd_reg, rd_next; // read data
  logic pos_reg, neg_reg; // reference selects
  logic cmp_sync; // comparator decision latched on the clock

  logic gate; // converter clock gate
  logic tick; // one-cycle fAD enable
  logic [5:0] div_max; // divider terminal count
  logic [3:0] samp_len; // sampling length
  logic [3:0] last_bit; // lowest bit to trial
  logic [7:0] wval; // value after a bit or byte write
  logic [7:0] cur; // register under write
  logic [9:0] res; // final result at completion
  logic in_limit; // result inside the limit window

  // divider terminal count (divisor minus one) from the clock select field
  function automatic logic [5:0] fr_div(input logic [2:0] fr);
    unique case (fr)
      3'h0: fr_div = 6'h3f;
      3'h1: fr_div = 6'h1f;
      3'h2: fr_div = 6'h0f;
      3'h3: fr_div = 6'h07;
      3'h4: fr_div = 6'h05;
      3'h5: fr_div = 6'h04;
      3'h6: fr_div = 6'h03;
      3'h7: fr_div = 6'h01;
    endcase
  endfunction : fr_div

  // the comparator answers from our own registered tap and held sample, so it is
  // already in this clock's domain; one stage keeps one decision per conversion
  // clock at the fastest divide, where a second stage would still see the old trial
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_sync <= 1'b0;
    end else begin
      cmp_sync <= cmp_above;
    end
  end

  // next-state logic for registers and sequencer
  always_comb begin
    state_next = state_reg;
    per_next = per_reg;
    adm_next = adm_reg;
    div_next = div_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sar_next = sar_reg;
    scan_next = scan_reg;
    ch_next = ch_reg;
    sh_next = sh_reg;
    rw_next = rw_reg;
    rb_next = rb_reg;
    irq_next = 1'b0;
    rd_next = rd_reg;
    gate = per_reg[GATE_BIT];
    div_max = fr_div(adm_reg[FR_LSB +: 3]);
    tick = (div_reg == div_max);
    // low lv bit picks the shorter sampling window
    samp_len = adm_reg[LV_LSB] ? SAMPLE_STD2 : SAMPLE_STD1;
    last_bit = cfg.resolution_select ? LAST_BIT_8 : LAST_BIT_10;
    res = sar_reg;
    res[bit_reg] = cmp_sync;
    in_limit = (res[9:2] <= cfg.upper_limit) && (res[9:2] >= cfg.lower_limit);
    cur = (sfr_req.addr == PER_CLK_EN_ADDR) ? per_reg : adm_reg;
    wval = sfr_req.wdata;
    if (sfr_req.bit_wr) begin
      wval = cur;
      wval[sfr_req.bit_idx] = sfr_req.wdata[0];
    end
    // divider runs only while a phase is timed
    if (state_reg == ST_IDLE || tick) begin
      div_next = 6'h00;
    end else begin
      div_next = div_reg + 6'h01;
    end
    // processor writes
    if (sfr_req.wr && sfr_req.addr == PER_CLK_EN_ADDR) begin
      per_next = wval & ~PER_RSVD_MASK;
    end
    if (sfr_req.wr && sfr_req.addr == MODE_CTRL_ADDR && gate) begin
      adm_next = wval;
      // start may not be set by software in hardware wait mode
      if (cfg.trig_mode == TRIG_HW_WAIT && !adm_reg[START_BIT]) begin
        adm_next[START_BIT] = 1'b0;
      end
      // software start, ignored while the comparator is off
      if (cfg.trig_mode == TRIG_SW && wval[START_BIT] && !adm_reg[START_BIT] &&
          wval[CMP_EN_BIT] && state_reg == ST_IDLE) begin
        state_next = ST_SAMPLE;
      end
    end
    // hardware triggers
    if (state_reg == ST_IDLE && hw_trigger && adm_reg[CMP_EN_BIT]) begin
      if (cfg.trig_mode == TRIG_HW_NOWAIT && adm_reg[START_BIT]) begin
        state_next = ST_SAMPLE;
      end else if (cfg.trig_mode == TRIG_HW_WAIT && !adm_reg[START_BIT]) begin
        adm_next[START_BIT] = 1'b1;
        state_next = ST_STAB;
      end
    end
    // entering a conversion loads the first channel
    if (state_reg == ST_IDLE && state_next != ST_IDLE) begin
      ch_next = cfg.channel_spec;
      scan_next = 2'h0;
      cnt_next = 4'h0;
      sh_next = (state_next == ST_SAMPLE);
    end
    // timed phases advance on the conversion clock
    if (tick) begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_STAB: begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == STAB_FAD - 4'h1) begin
            cnt_next = 4'h0;
            sh_next = 1'b1;
            state_next = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == samp_len - 4'h1) begin
            cnt_next = 4'h0;
            sh_next = 1'b0;
            bit_next = TOP_BIT;
            sar_next = 10'h200;
            state_next = ST_CONV;
          end
        end
        ST_CONV: begin
          sar_next = res;
          if (bit_reg != last_bit) begin
            bit_next = bit_reg - 4'h1;
            sar_next[bit_reg - 4'h1] = 1'b1;
          end else begin
            // each completion overwrites both results
            rw_next = {res, 6'h00};
            rb_next = res[9:2];
            sh_next = 1'b1;
            state_next = ST_SAMPLE;
            if (adm_reg[CHMODE_BIT] && scan_reg != SCAN_LAST) begin
              scan_next = scan_reg + 2'h1;
              ch_next = ch_reg + 3'h1;
            end else begin
              irq_next = in_limit;
              scan_next = 2'h0;
              ch_next = cfg.channel_spec;
              if (cfg.one_shot) begin
                sh_next = 1'b0;
                state_next = ST_IDLE;
                // no-wait keeps start set; a same-cycle software set wins
                if (cfg.trig_mode != TRIG_HW_NOWAIT && !(sfr_req.wr &&
                    sfr_req.addr == MODE_CTRL_ADDR && wval[START_BIT])) begin
                  adm_next[START_BIT] = 1'b0;
                end
              end
            end
          end
        end
      endcase
    end
    // clearing start or enable stops any conversion
    if (!adm_next[START_BIT] || !adm_next[CMP_EN_BIT]) begin
      state_next = ST_IDLE;
      sh_next = 1'b0;
    end
    // gate low holds the converter in reset
    if (!per_next[GATE_BIT]) begin
      adm_next = MODE_CTRL_RST;
      state_next = ST_IDLE;
      sh_next = 1'b0;
      sar_next = 10'h000;
      rw_next = 16'h0000;
      rb_next = 8'h00;
      irq_next = 1'b0;
      cnt_next = 4'h0;
    end
    // read port, unmapped addresses read zero
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        PER_CLK_EN_ADDR: rd_next = per_reg;
        MODE_CTRL_ADDR: rd_next = adm_reg;
        default: rd_next = 8'h00;
      endcase
    end
  end

  // register stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      per_reg <= PER_CLK_EN_RST;
      adm_reg <= MODE_CTRL_RST;
      div_reg <= 6'h00;
      cnt_reg <= 4'h0;
      bit_reg <= 4'h0;
      sar_reg <= 10'h000;
      scan_reg <= 2'h0;
      ch_reg <= 3'h0;
      sh_reg <= 1'b0;
      rw_reg <= 16'h0000;
      rb_reg <= 8'h00;
      irq_reg <= 1'b0;
      rd_reg <= 8'h00;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      per_reg <= per_next;
      adm_reg <= adm_next;
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sar_reg <= sar_next;
      scan_reg <= scan_next;
      ch_reg <= ch_next;
      sh_reg <= sh_next;
      rw_reg <= rw_next;
      rb_reg <= rb_next;
      irq_reg <= irq_next;
      rd_reg <= rd_next;
      // external positive reference pin only for the 0/1 code; negative pin follows neg_ref_sel
      pos_reg <= !cfg.pos_ref_sel_hi && cfg.pos_ref_sel_lo;
      neg_reg <= cfg.neg_ref_sel;
    end
  end

  // all outputs straight from flops
  assign sfr_rdata = rd_reg;
  assign sar_tap = sar_reg;
  assign sample_hold = sh_reg;
  assign channel_sel = ch_reg;
  assign comparator_on = adm_reg[CMP_EN_BIT];
  assign converter_clock_gate = per_reg[GATE_BIT];
  assign ref_pos_ext = pos_reg;
  assign ref_neg_ext = neg_reg;
  assign result_word = rw_reg;
  assign result_byte = rb_reg;
  assign conversion_end_irq = irq_reg;
endmodule : sar_adc_controller
`default_nettype wire

// ==== adc_ctrl_pkg.sv ====
// shared constants and carrier types for the converter controller
`default_nettype none
package adc_ctrl_pkg;
  // register addresses and reset values
  localparam logic [19:0] PER_CLK_EN_ADDR = 20'hf00f0;
  localparam logic [19:0] MODE_CTRL_ADDR = 20'hfff30;
  localparam logic [7:0] PER_CLK_EN_RST = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] PER_RSVD_MASK = 8'h0a;
  // field positions
  localparam int GATE_BIT = 5;
  localparam int START_BIT = 7;
  localparam int CHMODE_BIT = 6;
  localparam int FR_LSB = 3;
  localparam int LV_LSB = 1;
  localparam int CMP_EN_BIT = 0;
  // timing counts in conversion-clock cycles, then scan and bit limits
  localparam logic [3:0] SAMPLE_STD1 = 4'h7;
  localparam logic [3:0] SAMPLE_STD2 = 4'h5;
  localparam logic [3:0] STAB_FAD = 4'h8;
  localparam logic [1:0] SCAN_LAST = 2'h3;
  localparam logic [3:0] LAST_BIT_10 = 4'h0;
  localparam logic [3:0] LAST_BIT_8 = 4'h2;
  localparam logic [3:0] TOP_BIT = 4'h9;
  // trigger mode codes
  localparam logic [1:0] TRIG_SW = 2'h0;
  localparam logic [1:0] TRIG_HW_NOWAIT = 2'h2;
  localparam logic [1:0] TRIG_HW_WAIT = 2'h3;
  // processor register access
  typedef struct packed {
    logic [19:0] addr;
    logic wr;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
    logic rd;
  } sfr_req_t;
  // static configuration held outside this block
  typedef struct packed {
    logic [1:0] trig_mode;
    logic one_shot;
    logic resolution_select;
    logic pos_ref_sel_hi;
    logic pos_ref_sel_lo;
    logic neg_ref_sel;
    logic [2:0] channel_spec;
    logic [7:0] upper_limit;
    logic [7:0] lower_limit;
  } conv_cfg_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ==== sar_adc_controller_assertions.sv ====
// port-level checks on the converter controller
`default_nettype none
module sar_adc_controller_assertions
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // watched ports
  input wire sfr_req_t sfr_req,
  input wire conv_cfg_t cfg,
  input wire logic [9:0] sar_tap,
  input wire logic sample_hold,
  input wire logic comparator_on,
  input wire logic converter_clock_gate,
  input wire logic ref_pos_ext,
  input wire logic [15:0] result_word,
  input wire logic [7:0] result_byte,
  input wire logic conversion_end_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // end of sampling not caused by a stop write
  sequence hold_ends_s; $fell(sample_hold) && !$past(sfr_req.wr); endsequence
  // top bit just decided, not a clear by a gate-off write
  sequence msb_done_s;
    $past(sar_tap) == 10'h200 && sar_tap != 10'h200 && !$past(sfr_req.wr);
  endsequence
  word_low_zero_a: assert property (result_word[5:0] == 6'h00)
    else $error("low result bits not zero");
  byte_upper_a: assert property (result_byte == result_word[15:8])
    else $error("byte result differs from word");
  gate_reset_a: assert property (!$past(converter_clock_gate) && !converter_clock_gate |->
    result_word == 16'h0000 && !sample_hold && !comparator_on) else $error("gate off not reset");
  irq_window_a: assert property (conversion_end_irq |->
    result_byte >= cfg.lower_limit && result_byte <= cfg.upper_limit) else $error("irq outside");
  irq_pulse_a: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("irq longer than one cycle");
  eight_bit_a: assert property (conversion_end_irq && cfg.resolution_select |->
    result_word[7:6] == 2'b00) else $error("8-bit result has low bits");
  ref_follow_a: assert property ($past(arst_n) |-> ref_pos_ext ==
    (!$past(cfg.pos_ref_sel_hi) && $past(cfg.pos_ref_sel_lo))) else $error("ref select wrong");
  stop_now_a: assert property (sfr_req.wr && !sfr_req.bit_wr && sfr_req.addr == MODE_CTRL_ADDR
    && !sfr_req.wdata[START_BIT] && converter_clock_gate |=> !sample_hold) else $error("no stop");
  first_trial_a: assert property (hold_ends_s |-> sar_tap == 10'h200)
    else $error("first trial not half");
  next_trial_a: assert property (msb_done_s |-> sar_tap[8] && sar_tap[7:0] == 8'h00)
    else $error("second trial wrong");
endmodule : sar_adc_controller_assertions
bind sar_adc_controller sar_adc_controller_assertions chk_u (.core_clk, .arst_n, .sfr_req,
  .cfg, .sar_tap, .sample_hold, .comparator_on, .converter_clock_gate, .ref_pos_ext,
  .result_word, .result_byte, .conversion_end_irq);
`default_nettype wire

// ==== analog_front_model.sv ====
// behavioural sample-and-hold and comparator on the far side
`default_nettype none
module analog_front_model (
  // clock
  input wire logic core_clk,
  // converter side
  input wire logic [9:0] sar_tap,
  input wire logic [2:0] channel_sel,
  input wire logic sample_hold,
  input wire logic comparator_on,
  input wire logic [79:0] vin,
  output logic cmp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held = '0; // voltage kept while converting
  logic wobble = 1'b0; // unpowered comparator gives no stable answer
  // capture the chosen input while sampling
  always @(posedge core_clk) begin
    wobble <= ~wobble;
    if (sample_hold) held <= vin[channel_sel*10 +: 10];
  end
  // at or above the tap reads high
  assign cmp_above = comparator_on ? (held >= sar_tap) : wobble;
endmodule : analog_front_model
`default_nettype wire

// ==== sar_adc_controller_bench.sv ====
// self-checking bench for the converter controller
`default_nettype none
module sar_adc_controller_bench import adc_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, arst_n = 1'b0, hw_trigger = 1'b0;
  sfr_req_t sfr_req = '0;
  conv_cfg_t cfg = '{upper_limit: 8'hff, default: '0};
  logic [79:0] vin = '0;
  logic [7:0] rdat, sfr_rdata, result_byte;
  logic [9:0] sar_tap;
  logic [2:0] channel_sel;
  logic [15:0] result_word;
  logic sample_hold, comparator_on, converter_clock_gate, ref_pos_ext, ref_neg_ext;
  logic cmp_above, conversion_end_irq;
  int fails = 0, samples_checked = 0, hold_len = 0, hold_cnt = 0, irqs;
  sar_adc_controller dut_u (.core_clk, .arst_n, .sfr_req, .sfr_rdata, .cfg, .hw_trigger,
    .cmp_above, .sar_tap, .sample_hold, .channel_sel, .comparator_on, .converter_clock_gate,
    .ref_pos_ext, .ref_neg_ext, .result_word, .result_byte, .conversion_end_irq);
  analog_front_model afe_u (.core_clk, .sar_tap, .channel_sel, .sample_hold,
    .comparator_on, .vin, .cmp_above);
  always #25 core_clk = ~core_clk;
  // length of the last finished sampling window, in core clocks
  always @(posedge core_clk) begin
    if (sample_hold) hold_cnt <= hold_cnt + 1;
    else if (hold_cnt != 0) begin
      hold_len <= hold_cnt;
      hold_cnt <= 0;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic b = 1'b0,
                    input logic [2:0] i = 3'h0);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.bit_wr = b;
    sfr_req.bit_idx = i;
    sfr_req.wr = 1'b1;
    tick(1);
    sfr_req.wr = 1'b0;
    // let an edge pass so a following write raises the strobe afresh
    tick(1);
  endtask : wr
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    tick(1);
    sfr_req.rd = 1'b0;
    tick(1);
    d = sfr_rdata;
  endtask : rd
  // count irq pulses
  task automatic run(input int n);
    irqs = 0;
    repeat (n) begin
      tick(1);
      irqs += conversion_end_irq;
    end
  endtask : run
  // stopped mode write, then enable, settle, then optional start
  task automatic go(input logic [7:0] m, input logic s);
    wr(MODE_CTRL_ADDR, m);
    wr(MODE_CTRL_ADDR, 8'h01, 1'b1, 3'h0);
    tick(20);
    if (s) wr(MODE_CTRL_ADDR, 8'h01, 1'b1, 3'h7);
  endtask : go
  task automatic t_regs;
    rd(PER_CLK_EN_ADDR, rdat); chk(rdat, PER_CLK_EN_RST);
    wr(MODE_CTRL_ADDR, 8'h39);
    rd(MODE_CTRL_ADDR, rdat); chk(rdat, MODE_CTRL_RST);
    wr(PER_CLK_EN_ADDR, 8'hff);
    rd(PER_CLK_EN_ADDR, rdat); chk(rdat, 8'hff & ~PER_RSVD_MASK);
    wr(PER_CLK_EN_ADDR, 8'h00);
    wr(PER_CLK_EN_ADDR, 8'h01, 1'b1, 3'h5);
    rd(PER_CLK_EN_ADDR, rdat); chk(rdat, 8'h20);
    chk(converter_clock_gate, 1'b1);
    rd(20'h00000, rdat); chk(rdat, 8'h00);
  endtask : t_regs
  task automatic t_select;
    cfg.channel_spec = 3'h5;
    cfg.one_shot = 1'b1;
    vin[50+:10] = 10'h2a5;
    go(8'h38, 1'b0);
    run(10); chk(irqs, 0);
    chk(comparator_on, 1'b1);
    wr(MODE_CTRL_ADDR, 8'h01, 1'b1, 3'h7);
    run(60); chk(irqs, 1);
    chk(channel_sel, 3'h5);
    chk(16'(hold_len), 16'(2 * SAMPLE_STD1));
    chk(result_word, 16'ha940);
    chk(result_byte, 8'ha9);
    rd(MODE_CTRL_ADDR, rdat); chk(rdat, 8'h39);
  endtask : t_select
  task automatic t_res8;
    cfg.resolution_select = 1'b1;
    go(8'h3a, 1'b1);
    run(60); chk(16'(hold_len), 16'(2 * SAMPLE_STD2));
    chk(result_word, 16'ha900);
    cfg.resolution_select = 1'b0;
  endtask : t_res8
  task automatic t_scan;
    cfg.channel_spec = 3'h6;
    vin[10+:10] = 10'h155;
    go(8'h78, 1'b1);
    run(200); chk(irqs, 1);
    chk(result_word, 16'h5540);
  endtask : t_scan
  task automatic t_nowait;
    cfg.trig_mode = TRIG_HW_NOWAIT;
    go(8'h38, 1'b1);
    run(40); chk(irqs, 0);
    hw_trigger = 1'b1;
    tick(1);
    hw_trigger = 1'b0;
    run(60); chk(irqs, 1);
    rd(MODE_CTRL_ADDR, rdat); chk(rdat, 8'hb9);
    wr(MODE_CTRL_ADDR, 8'h39);
  endtask : t_nowait
  task automatic t_wait;
    cfg.trig_mode = TRIG_HW_WAIT;
    vin[60+:10] = 10'h0f0;
    go(8'h38, 1'b0);
    hw_trigger = 1'b1;
    tick(1);
    hw_trigger = 1'b0;
    rd(MODE_CTRL_ADDR, rdat); chk(rdat, 8'hb9);
    run(80); chk(irqs, 1);
    chk(result_word, 16'h3c00);
    rd(MODE_CTRL_ADDR, rdat); chk(rdat, 8'h39);
  endtask : t_wait
  task automatic t_seq;
    cfg.trig_mode = TRIG_SW;
    cfg.one_shot = 1'b0;
    cfg.upper_limit = 8'h10;
    vin[60+:10] = 10'h3ff;
    go(8'h38, 1'b1);
    run(80); chk(irqs, 0);
    chk(result_word, 16'hffc0);
    vin[60+:10] = 10'h001;
    run(120); chk(16'(irqs > 1), 16'h1);
    chk(result_word, 16'h0040);
    wr(MODE_CTRL_ADDR, 8'h39);
    run(80); chk(irqs, 0);
    cfg.upper_limit = 8'hff;
  endtask : t_seq
  task automatic t_gate;
    cfg.pos_ref_sel_lo = 1'b1;
    cfg.neg_ref_sel = 1'b1;
    tick(2); chk(ref_pos_ext, 1'b1);
    chk(ref_neg_ext, 1'b1);
    wr(PER_CLK_EN_ADDR, 8'h00);
    wr(MODE_CTRL_ADDR, 8'h39);
    rd(MODE_CTRL_ADDR, rdat); chk(rdat, 8'h00);
    chk(result_word, 16'h0000);
    chk(converter_clock_gate, 1'b0);
    chk(comparator_on, 1'b0);
  endtask : t_gate
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // watchdog well beyond the expected run length
  initial begin
    #200us;
    fails++;
    give_verdict;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_regs;
    t_select;
    t_res8;
    t_scan;
    t_nowait;
    t_wait;
    t_seq;
    t_gate;
    give_verdict;
  end
endmodule : sar_adc_controller_bench
`default_nettype wire
